// *** common/codec_ctrl_pkg.sv ***
// constants for the codec control register bank
// assumes one 40 MHz clock and a register port of secondary frames
package codec_ctrl_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam logic [4:0] NULL_REGISTER_OFS = 5'h00;
   localparam logic [4:0] POWER_RESET_CONTROL_OFS = 5'h01;
   localparam logic [4:0] FILTER_LOOP_PLL_CONTROL_OFS = 5'h02;
   localparam logic [4:0] PLL_INPUT_DIVIDER_OFS = 5'h03;
   localparam logic [4:0] PLL_FEEDBACK_MULTIPLIER_OFS = 5'h04;
   localparam logic [4:0] RECEIVE_INPUT_GAIN_OFS = 5'h05;
   localparam logic [4:0] ADC_VOLUME_OFS = 5'h06;
   localparam logic [4:0] DAC_VOLUME_OFS = 5'h07;
   localparam logic [4:0] SHORT_CIRCUIT_STATUS_OFS = 5'h08;
   localparam logic [4:0] OUTPUT_ATTENUATION_OFS = 5'h09;
   // register 1 fields
   localparam int SOFT_RESET_BIT_POS = 7;
   localparam int SPEAKER_DRIVE_ON_POS = 4;
   localparam int LINE_DRIVE_ON_POS = 3;
   localparam int HANDSET_DRIVE_ON_POS = 2;
   localparam int MIC_BIAS_OFF_POS = 1;
   localparam int CHIP_SLEEP_POS = 0;
   localparam logic [7:0] CTRL1_MASK = 8'h1F;
   // register 2 fields
   localparam int HIGHPASS_BYPASS_POS = 4;
   localparam int PLL_DIV10_POS = 3;
   localparam int ANALOG_LOOPBACK_POS = 2;
   localparam int BITSTREAM_LOOPBACK_POS = 1;
   localparam logic [7:0] CTRL2_MASK = 8'h1E;
   // masks of registers 6..9
   localparam logic [7:0] ADC_VOLUME_MASK = 8'h7F;
   localparam logic [7:0] DAC_VOLUME_MASK = 8'h7F;
   localparam logic [7:0] STATUS_MASK = 8'hE0;
   localparam logic [7:0] ATTEN_MASK = 8'h0F;
   // reset values
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] PLL_DIV_RESET = 8'h00;
   localparam logic [7:0] PLL_MUL_RESET = 8'h00;
   localparam logic [7:0] RX_GAIN_RESET = 8'h47;
   localparam logic [7:0] ADC_VOLUME_RESET = 8'h5C;
   localparam logic [7:0] DAC_VOLUME_RESET = 8'h5C;
   localparam logic [7:0] ATTEN_RESET = 8'h00;
   localparam logic [3:0] FINAL_DIV_TEN = 4'hA;
   localparam logic [3:0] FINAL_DIV_FIVE = 4'h5;
   typedef enum logic [1:0] {LOOP_NONE, LOOP_ANALOG, LOOP_BITSTREAM, LOOP_BOTH} loop_mode_t;
endpackage

// *** design/sleep_wake_ctrl.sv ***
// sleep state holder: enters on the sleep bit, leaves on a reset pulse
// assumes resetPinN is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic sleepReq,
   input wire logic resetPinN,
   output logic asleep
);
   logic asleep_q, asleep_d;
   always_comb begin
      asleep_d = asleep_q;
      if (!resetPinN) begin
         asleep_d = 1'b0;
      end else if (sleepReq) begin
         asleep_d = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         asleep_q <= 1'b0;
      end else begin
         asleep_q <= asleep_d;
      end
   end
   assign asleep = asleep_q;
   a_stay_asleep: assert property (@(posedge clk) disable iff (rst)
      asleep_q && resetPinN |=> asleep_q)
      else $error("sleep left without reset pulse");
endmodule
`default_nettype wire

// *** design/codec_control_register_bank.sv ***
// control register bank of the voice codec, reached through secondary frames
// assumes frame decoding elsewhere hands one access per frame as a strobe
//
// Notes on behaviour
// - sleep bit set puts device to sleep
// - only a low reset pulse ends sleep
// - loopback one routes via DAC and ADC
// - loopback two routes one-bit DAC to ADC
// - address zero reads zero, writes ignored
// - soft reset clears all, self-clears; here it loads register defaults and leaves the sleep state set
// - speaker bit one enables both speakers
// - line bit one enables line driver
// - handset bit one enables handset driver
// - mic bias bit one powers bias down
// - highpass bypass bit skips the filter
// - final PLL stage divides ten or five
// - PLL fields store value minus one
// - both PLL fields zero bypasses PLL
// - one register access per frame
`timescale 1ns/1ps
`default_nettype none
module codec_control_register_bank
   import codec_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic resetPinN,
   input wire logic accessStrobe,
   input wire logic accessRead,
   input wire logic [codec_ctrl_pkg::ADDR_W-1:0] accessAddr,
   input wire logic [codec_ctrl_pkg::DATA_W-1:0] accessWdata,
   input wire logic [2:0] shortStatus,
   output logic [codec_ctrl_pkg::DATA_W-1:0] readData,
   output logic readValid,
   output logic chipAsleep,
   output logic speakerDriveOn,
   output logic lineDriveOn,
   output logic handsetDriveOn,
   output logic micBiasOff,
   output logic highpassBypass,
   output logic [3:0] pllFinalDivide,
   output logic [8:0] pllDividerValue,
   output logic [8:0] pllMultiplierValue,
   output logic pllBypass,
   output codec_ctrl_pkg::loop_mode_t loopMode,
   output logic [7:0] receiveInputGain,
   output logic [7:0] adcVolume,
   output logic [7:0] dacVolume,
   output logic [7:0] outputAttenuation
);
   import codec_ctrl_pkg::*;

   // ==========================================================
   // register state
   logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, div_q, div_d, mul_q, mul_d;
   logic [7:0] rxg_q, rxg_d, adcv_q, adcv_d, dacv_q, dacv_d, att_q, att_d;
   logic [7:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic asleep;
   logic wr, softReset, sleepReq;

   // wake reset pulse also restores defaults, so the host must reprogram
   assign wr = accessStrobe && !accessRead;
   assign softReset = wr && accessAddr == POWER_RESET_CONTROL_OFS
      && accessWdata[SOFT_RESET_BIT_POS];
   assign sleepReq = ctrl1_q[CHIP_SLEEP_POS];

   function automatic logic [7:0] readMux(input logic [4:0] a);
      unique case (a)
         POWER_RESET_CONTROL_OFS: readMux = ctrl1_q;
         FILTER_LOOP_PLL_CONTROL_OFS: readMux = ctrl2_q;
         PLL_INPUT_DIVIDER_OFS: readMux = div_q;
         PLL_FEEDBACK_MULTIPLIER_OFS: readMux = mul_q;
         RECEIVE_INPUT_GAIN_OFS: readMux = rxg_q;
         ADC_VOLUME_OFS: readMux = adcv_q;
         DAC_VOLUME_OFS: readMux = dacv_q;
         SHORT_CIRCUIT_STATUS_OFS: readMux = {shortStatus, 5'h00} & STATUS_MASK;
         OUTPUT_ATTENUATION_OFS: readMux = att_q;
         default: readMux = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // write and read decode
   always_comb begin
      ctrl1_d = ctrl1_q;
      ctrl2_d = ctrl2_q;
      div_d = div_q;
      mul_d = mul_q;
      rxg_d = rxg_q;
      adcv_d = adcv_q;
      dacv_d = dacv_q;
      att_d = att_q;
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      if (softReset || !resetPinN) begin
         // soft reset bit never stored, so it reads back cleared
         ctrl1_d = CTRL1_RESET;
         ctrl2_d = CTRL2_RESET;
         div_d = PLL_DIV_RESET;
         mul_d = PLL_MUL_RESET;
         rxg_d = RX_GAIN_RESET;
         adcv_d = ADC_VOLUME_RESET;
         dacv_d = DAC_VOLUME_RESET;
         att_d = ATTEN_RESET;
      end else if (wr) begin
         unique case (accessAddr)
            POWER_RESET_CONTROL_OFS: ctrl1_d = accessWdata & CTRL1_MASK;
            FILTER_LOOP_PLL_CONTROL_OFS: ctrl2_d = accessWdata & CTRL2_MASK;
            PLL_INPUT_DIVIDER_OFS: div_d = accessWdata;
            PLL_FEEDBACK_MULTIPLIER_OFS: mul_d = accessWdata;
            RECEIVE_INPUT_GAIN_OFS: rxg_d = accessWdata;
            ADC_VOLUME_OFS: adcv_d = accessWdata & ADC_VOLUME_MASK;
            DAC_VOLUME_OFS: dacv_d = accessWdata & DAC_VOLUME_MASK;
            OUTPUT_ATTENUATION_OFS: att_d = accessWdata & ATTEN_MASK;
            default: ;
         endcase
      end
      if (accessStrobe && accessRead) begin
         rdata_d = readMux(accessAddr);
         rvalid_d = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl1_q <= CTRL1_RESET;
         ctrl2_q <= CTRL2_RESET;
         div_q <= PLL_DIV_RESET;
         mul_q <= PLL_MUL_RESET;
         rxg_q <= RX_GAIN_RESET;
         adcv_q <= ADC_VOLUME_RESET;
         dacv_q <= DAC_VOLUME_RESET;
         att_q <= ATTEN_RESET;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         ctrl1_q <= ctrl1_d;
         ctrl2_q <= ctrl2_d;
         div_q <= div_d;
         mul_q <= mul_d;
         rxg_q <= rxg_d;
         adcv_q <= adcv_d;
         dacv_q <= dacv_d;
         att_q <= att_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ==========================================================
   // sleep control
   sleep_wake_ctrl sleepCtl (
      .clk(clk),
      .rst(rst),
      .sleepReq(sleepReq),
      .resetPinN(resetPinN),
      .asleep(asleep)
   );

   // ==========================================================
   // registered control outputs
   logic spk_q, line_q, hs_q, mic_q, hpf_q, byp_q, sleepOut_q;
   logic spk_d, line_d, hs_d, mic_d, hpf_d, byp_d, sleepOut_d;
   logic [3:0] fdiv_q, fdiv_d;
   logic [8:0] dv_q, dv_d, mv_q, mv_d;
   loop_mode_t loop_q, loop_d;

   always_comb begin
      sleepOut_d = asleep;
      spk_d = ctrl1_q[SPEAKER_DRIVE_ON_POS] && !asleep;
      line_d = ctrl1_q[LINE_DRIVE_ON_POS] && !asleep;
      hs_d = ctrl1_q[HANDSET_DRIVE_ON_POS] && !asleep;
      mic_d = ctrl1_q[MIC_BIAS_OFF_POS] || asleep;
      hpf_d = ctrl2_q[HIGHPASS_BYPASS_POS];
      fdiv_d = ctrl2_q[PLL_DIV10_POS] ? FINAL_DIV_TEN : FINAL_DIV_FIVE;
      dv_d = {1'b0, div_q} + 9'h001;
      mv_d = {1'b0, mul_q} + 9'h001;
      byp_d = div_q == 8'h00 && mul_q == 8'h00;
      loop_d = loop_mode_t'({ctrl2_q[BITSTREAM_LOOPBACK_POS],
         ctrl2_q[ANALOG_LOOPBACK_POS]});
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sleepOut_q <= 1'b0;
         spk_q <= 1'b0;
         line_q <= 1'b0;
         hs_q <= 1'b0;
         mic_q <= 1'b0;
         hpf_q <= 1'b0;
         fdiv_q <= FINAL_DIV_FIVE;
         dv_q <= 9'h001;
         mv_q <= 9'h001;
         byp_q <= 1'b1;
         loop_q <= LOOP_NONE;
      end else begin
         sleepOut_q <= sleepOut_d;
         spk_q <= spk_d;
         line_q <= line_d;
         hs_q <= hs_d;
         mic_q <= mic_d;
         hpf_q <= hpf_d;
         fdiv_q <= fdiv_d;
         dv_q <= dv_d;
         mv_q <= mv_d;
         byp_q <= byp_d;
         loop_q <= loop_d;
      end
   end

   assign readData = rdata_q;
   assign readValid = rvalid_q;
   assign chipAsleep = sleepOut_q;
   assign speakerDriveOn = spk_q;
   assign lineDriveOn = line_q;
   assign handsetDriveOn = hs_q;
   assign micBiasOff = mic_q;
   assign highpassBypass = hpf_q;
   assign pllFinalDivide = fdiv_q;
   assign pllDividerValue = dv_q;
   assign pllMultiplierValue = mv_q;
   assign pllBypass = byp_q;
   assign loopMode = loop_q;
   assign receiveInputGain = rxg_q;
   assign adcVolume = adcv_q;
   assign dacVolume = dacv_q;
   assign outputAttenuation = att_q;

   // ==========================================================
   // checks
   a_null_reads_zero: assert property (@(posedge clk) disable iff (rst)
      accessStrobe && accessRead && accessAddr == NULL_REGISTER_OFS
      |=> readValid && readData == 8'h00)
      else $error("register zero read nonzero");
   a_soft_reset_clears: assert property (@(posedge clk) disable iff (rst)
      softReset && resetPinN |=> ctrl1_q == CTRL1_RESET && rxg_q == RX_GAIN_RESET
      && !ctrl1_q[SOFT_RESET_BIT_POS])
      else $error("soft reset did not restore defaults");
   a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
      ctrl1_q[CHIP_SLEEP_POS] && resetPinN |=> ##1 chipAsleep)
      else $error("sleep bit did not sleep chip");
   a_speaker_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 speakerDriveOn == $past(ctrl1_q[SPEAKER_DRIVE_ON_POS] && !asleep))
      else $error("speaker drive mismatch");
   a_line_follow: assert property (@(posedge clk) disable iff (rst)
      !ctrl1_q[LINE_DRIVE_ON_POS] |=> !lineDriveOn)
      else $error("line driver not powered down");
   a_handset_follow: assert property (@(posedge clk) disable iff (rst)
      !ctrl1_q[HANDSET_DRIVE_ON_POS] |=> !handsetDriveOn)
      else $error("handset driver not powered down");
   a_mic_polarity: assert property (@(posedge clk) disable iff (rst)
      ctrl1_q[MIC_BIAS_OFF_POS] |=> micBiasOff)
      else $error("mic bias not powered down");
   a_hpf_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 highpassBypass == $past(ctrl2_q[HIGHPASS_BYPASS_POS]))
      else $error("highpass bypass mismatch");
   a_final_divide: assert property (@(posedge clk) disable iff (rst)
      ctrl2_q[PLL_DIV10_POS] |=> pllFinalDivide == 4'hA)
      else $error("final divide not ten");
   a_pll_plus_one: assert property (@(posedge clk) disable iff (rst)
      ##1 pllDividerValue == {1'b0, $past(div_q)} + 9'h001)
      else $error("divider value not plus one");
   a_pll_bypass: assert property (@(posedge clk) disable iff (rst)
      ##1 pllBypass == ($past(div_q) == 8'h00 && $past(mul_q) == 8'h00))
      else $error("pll bypass wrong");
   a_loop_modes: assert property (@(posedge clk) disable iff (rst)
      ctrl2_q[ANALOG_LOOPBACK_POS] && !ctrl2_q[BITSTREAM_LOOPBACK_POS]
      |=> loopMode == LOOP_ANALOG)
      else $error("analog loopback not selected");
   a_bitstream_loop: assert property (@(posedge clk) disable iff (rst)
      ctrl2_q[BITSTREAM_LOOPBACK_POS] && !ctrl2_q[ANALOG_LOOPBACK_POS]
      |=> loopMode == LOOP_BITSTREAM)
      else $error("bitstream loopback not selected");
   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      (ctrl1_q & ~CTRL1_MASK) == 8'h00 && (ctrl2_q & ~CTRL2_MASK) == 8'h00)
      else $error("reserved bit stored");
endmodule
`default_nettype wire

// *** verif/host_dsp_model.sv ***
// host side model: issues one register access per frame and drives the reset pin
// assumes the master clock runs throughout and accesses follow the strobe contract
`timescale 1ns/1ps
`default_nettype none
module host_dsp_model
   import codec_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic [codec_ctrl_pkg::DATA_W-1:0] readData,
   input wire logic readValid,
   output var logic resetPinN,
   output var logic accessStrobe,
   output var logic accessRead,
   output var logic [codec_ctrl_pkg::ADDR_W-1:0] accessAddr,
   output var logic [codec_ctrl_pkg::DATA_W-1:0] accessWdata
);
   // ==========================================
   // access tasks
   initial begin
      resetPinN = 1'b1;
      accessStrobe = 1'b0;
      accessRead = 1'b0;
      accessAddr = 5'h00;
      accessWdata = 8'h00;
   end
   // one access per frame, fields held through the taking edge
   task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clk);
      #1;
      accessStrobe = 1'b1;
      accessRead = rd;
      accessAddr = a;
      accessWdata = d;
      @(posedge clk);
      #1;
      accessStrobe = 1'b0;
      // released fields must not look like the last request
      accessRead = ~rd;
      accessAddr = ~a;
      accessWdata = ~d;
      q = (readValid === 1'b1) ? readData : 8'hXX;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] unused;
      access(1'b0, a, d, unused);
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] q);
      access(1'b1, a, 8'h00, q);
   endtask
   // master clock never stops here, so the pulse always follows a live clock
   task automatic wake();
      @(posedge clk);
      #1;
      resetPinN = 1'b0;
      @(posedge clk);
      #1;
      resetPinN = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** verif/tb_codec_control_register_bank.sv ***
// self-checking bench for the codec control register bank
// assumes the host model drives the access port and the reset pin
`timescale 1ns/1ps
`default_nettype none
module tb_codec_control_register_bank;
   import codec_ctrl_pkg::*;
   // ==========================================
   // signals and tables
   localparam int POP_WAIT = 40;
   logic clk, rst, resetPinN, accessStrobe, accessRead, readValid, chipAsleep, pllBypass;
   logic speakerDriveOn, lineDriveOn, handsetDriveOn, micBiasOff, highpassBypass;
   logic [2:0] shortStatus;
   logic [3:0] pllFinalDivide;
   logic [4:0] accessAddr;
   logic [7:0] accessWdata, readData, receiveInputGain, adcVolume, dacVolume, outputAttenuation;
   logic [8:0] pllDividerValue, pllMultiplierValue;
   loop_mode_t loopMode;
   logic [7:0] q;
   int n_errors = 0;
   int checks_done = 0;
   logic [7:0] expRst [0:9] = '{8'h00, CTRL1_RESET, CTRL2_RESET, PLL_DIV_RESET, PLL_MUL_RESET,
      RX_GAIN_RESET, ADC_VOLUME_RESET, DAC_VOLUME_RESET, 8'h00, ATTEN_RESET};
   logic [7:0] expFf [0:10] = '{8'h00, CTRL1_MASK, CTRL2_MASK, 8'hFF, 8'hFF, 8'hFF,
      ADC_VOLUME_MASK, DAC_VOLUME_MASK, 8'h00, ATTEN_MASK, 8'h00};
   logic [7:0] c1 [0:5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h00, 8'h1E};
   logic [7:0] c2 [0:5] = '{8'h04, 8'h02, 8'h06, 8'h00, 8'h10, 8'h08};
   logic [7:0] pd [0:2] = '{8'h00, 8'h08, 8'hFF};
   logic [7:0] pm [0:2] = '{8'h00, 8'hC7, 8'h00};
   logic [2:0] ss [0:1] = '{3'b101, 3'b010};
   codec_control_register_bank dut_u (.clk, .rst, .resetPinN, .accessStrobe, .accessRead,
      .accessAddr, .accessWdata, .shortStatus, .readData, .readValid, .chipAsleep,
      .speakerDriveOn, .lineDriveOn, .handsetDriveOn, .micBiasOff, .highpassBypass,
      .pllFinalDivide, .pllDividerValue, .pllMultiplierValue, .pllBypass, .loopMode,
      .receiveInputGain, .adcVolume, .dacVolume, .outputAttenuation);
   host_dsp_model host_u (.clk, .readData, .readValid, .resetPinN, .accessStrobe,
      .accessRead, .accessAddr, .accessWdata);
   always #12.5 clk = ~clk;
   // ==========================================
   // compare and helper tasks
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: output %h, expected %h", $time, got, exp);
      end
   endtask
   // derived outputs trail a write by two edges; three leaves margin
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic chk_defaults();
      for (int i = 0; i < 10; i++) begin
         host_u.rd(5'(i), q);
         chk_reg(q, expRst[i]);
      end
      chk_out(9'(pllBypass), 9'h001);
      chk_out(pllDividerValue, 9'h001);
      chk_out(9'(speakerDriveOn), 9'h000);
      chk_out(9'(receiveInputGain), 9'(RX_GAIN_RESET));
      chk_out(9'(adcVolume), 9'(ADC_VOLUME_RESET));
      chk_out(9'(dacVolume), 9'(DAC_VOLUME_RESET));
      chk_out(9'(outputAttenuation), 9'(ATTEN_RESET));
   endtask
   task automatic tally_and_finish();
      $display("errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      shortStatus = 3'b000;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      chk_defaults();
      // reserved bits and addresses written on purpose, sleep bit set too
      for (int i = 0; i < 11; i++) host_u.wr(5'(i), (i == 1) ? 8'h7F : 8'hFF);
      for (int i = 0; i < 11; i++) begin
         host_u.rd(5'(i), q);
         chk_reg(q, expFf[i]);
      end
      settle();
      chk_out(9'(chipAsleep), 9'h001);
      chk_out(9'(lineDriveOn), 9'h000);
      chk_out(9'(micBiasOff), 9'h001);
      chk_out(9'(adcVolume), 9'(ADC_VOLUME_MASK));
      chk_out(9'(dacVolume), 9'(DAC_VOLUME_MASK));
      chk_out(9'(outputAttenuation), 9'(ATTEN_MASK));
      host_u.wake();
      settle();
      chk_out(9'(chipAsleep), 9'h000);
      chk_defaults();
      repeat (POP_WAIT) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         host_u.wr(POWER_RESET_CONTROL_OFS, c1[i]);
         host_u.wr(FILTER_LOOP_PLL_CONTROL_OFS, c2[i]);
         settle();
         chk_out(9'(speakerDriveOn), 9'(c1[i][SPEAKER_DRIVE_ON_POS]));
         chk_out(9'(lineDriveOn), 9'(c1[i][LINE_DRIVE_ON_POS]));
         chk_out(9'(handsetDriveOn), 9'(c1[i][HANDSET_DRIVE_ON_POS]));
         chk_out(9'(micBiasOff), 9'(c1[i][MIC_BIAS_OFF_POS]));
         chk_out(9'(chipAsleep), 9'h000);
         chk_out(9'(highpassBypass), 9'(c2[i][4]));
         chk_out(9'(pllFinalDivide), c2[i][3] ? 9'h00A : 9'h005);
         chk_out(9'(loopMode), 9'({c2[i][1], c2[i][2]}));
      end
      for (int i = 0; i < 3; i++) begin
         host_u.wr(PLL_INPUT_DIVIDER_OFS, pd[i]);
         host_u.wr(PLL_FEEDBACK_MULTIPLIER_OFS, pm[i]);
         settle();
         chk_out(pllDividerValue, 9'(pd[i]) + 9'h001);
         chk_out(pllMultiplierValue, 9'(pm[i]) + 9'h001);
         chk_out(9'(pllBypass), 9'((pd[i] | pm[i]) == 8'h00));
      end
      for (int i = 0; i < 2; i++) begin
         shortStatus = ss[i];
         host_u.rd(SHORT_CIRCUIT_STATUS_OFS, q);
         chk_reg(q, {ss[i], 5'h00});
      end
      shortStatus = 3'b000;
      host_u.wr(RECEIVE_INPUT_GAIN_OFS, 8'h12);
      host_u.rd(RECEIVE_INPUT_GAIN_OFS, q);
      chk_reg(q, 8'h12);
      host_u.wr(POWER_RESET_CONTROL_OFS, 8'h80);
      settle();
      chk_defaults();
      tally_and_finish();
   end
endmodule
`default_nettype wire
